// ### rtl/hvdc_pkg.sv
`default_nettype none
package hvdc_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 8;
  localparam int SETTLE_NORMAL_NS  = 10000;
  localparam int SETTLE_TURBO_NS   = 55000;
  localparam int STEP_UNIT_NS      = 2000;
  // all three times round down, never below one cycle
  localparam int SETTLE_NORMAL_CYC = (SETTLE_NORMAL_NS / CLK_PERIOD_NS < 1) ? 1 : SETTLE_NORMAL_NS / CLK_PERIOD_NS;
  localparam int SETTLE_TURBO_CYC  = (SETTLE_TURBO_NS / CLK_PERIOD_NS < 1) ? 1 : SETTLE_TURBO_NS / CLK_PERIOD_NS;
  localparam int STEP_UNIT_CYC     = (STEP_UNIT_NS / CLK_PERIOD_NS < 1) ? 1 : STEP_UNIT_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // output map
  // ---------------------------------------------------------------------------
  localparam int NUM_OUT        = 6;
  localparam int CODE_W         = 7;
  localparam int RAMP_STEPS     = 256;
  localparam int STEP_MV        = 188;
  localparam int STEP_CODE_W    = 5;

  // ---------------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] IDX_RAMP_ABC  = 6'h01;
  localparam logic [5:0] IDX_RAMP_DEF  = 6'h05;
  localparam logic [5:0] IDX_CODE_A    = 6'h02;
  localparam logic [5:0] IDX_CODE_D    = 6'h06;
  localparam logic [5:0] IDX_PROF_AB   = 6'h09;
  localparam logic [5:0] IDX_PROF_EF   = 6'h0B;
  localparam logic [5:0] IDX_STATUS    = 6'h0C;
  localparam logic [5:0] IDX_LEVEL_A   = 6'h10;
  localparam logic [5:0] IDX_LEVEL_F   = 6'h15;

  // ---------------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int FAST_SETTLE_BIT = 7;
  localparam int STEP_CODE_LSB   = 3;
  localparam int RB_HIZ_BIT      = 7;
  localparam int RB_MV_LSB       = 8;
  localparam int RB_SETTLED_BIT  = 24;
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'h00;
  localparam logic [7:0] RST_PROF = 8'h00;

  typedef enum logic [1:0] {
    HVDC_NORMAL,
    HVDC_TURBO,
    HVDC_GLIDE
  } hvdc_mode_t;

  // one high-voltage output as seen by the analog stage
  typedef struct packed {
    logic              drive;
    hvdc_mode_t        mode;
    logic [1:0]        profile;
    logic [CODE_W-1:0] level;
  } hvdc_chan_t;

  // point k of a 256-step ramp from s to t
  function automatic logic [CODE_W-1:0] hvdc_ramp_point(
    input logic [CODE_W-1:0] s,
    input logic [CODE_W-1:0] t,
    input logic [8:0]        k
  );
    logic signed [17:0] d;
    d = (signed'({11'h000, t}) - signed'({11'h000, s})) * signed'({9'h000, k});
    return CODE_W'(s + CODE_W'(d >>> 8));
  endfunction : hvdc_ramp_point

  // nominal output in millivolts
  function automatic logic [15:0] hvdc_level_mv(input logic [CODE_W-1:0] lvl);
    return 16'(lvl * STEP_MV);
  endfunction : hvdc_level_mv

endpackage : hvdc_pkg
`default_nettype wire

// ### rtl/hvdc_step_tick.sv
`timescale 1ns/10ps
`default_nettype none
module hvdc_step_tick
  import hvdc_pkg::*;
#(
  parameter int UNIT_CYC = STEP_UNIT_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   restart,
  input  wire logic [STEP_CODE_W-1:0] stepCode,
  output logic                        tick
);

  if (UNIT_CYC < 1 || UNIT_CYC > 255) begin : g_chk
    $error("hvdc_step_tick: UNIT_CYC out of range");
  end

  logic [12:0] cnt_q;
  logic [12:0] reload;

  // period is (code + 1) units; restart aligns the first step with the load
  assign reload = 13'((stepCode + 13'h0001) * UNIT_CYC - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 13'h0000;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= reload;
      tick  <= 1'b0;
    end else if (cnt_q == 13'h0000) begin
      cnt_q <= reload;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 13'h0001;
      tick  <= 1'b0;
    end
  end

endmodule : hvdc_step_tick
`default_nettype wire

// ### rtl/hvdc_channel.sv
`timescale 1ns/10ps
`default_nettype none
module hvdc_channel
  import hvdc_pkg::*;
#(
  parameter int NORMAL_CYC = SETTLE_NORMAL_CYC,
  parameter int TURBO_CYC  = SETTLE_TURBO_CYC
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              load,
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              fastSettle,
  input  wire logic              glideEn,
  input  wire logic [1:0]        profile,
  input  wire logic              stepTick,
  output hvdc_chan_t             chan,
  output logic                   settled
);

  if (NORMAL_CYC < 1 || TURBO_CYC < 1 || TURBO_CYC > 65535 || NORMAL_CYC > 65535) begin : g_chk
    $error("hvdc_channel: settle counts out of range");
  end

  logic [CODE_W-1:0] start_q;
  logic [CODE_W-1:0] target_q;
  logic [7:0]        step_q;
  logic              gliding_q;
  logic [15:0]       settle_q;

  // ---------------------------------------------------------------------------
  // level, drive and mode
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan      <= '0;
      start_q   <= '0;
      target_q  <= '0;
      step_q    <= 8'h00;
      gliding_q <= 1'b0;
    end else if (load) begin
      target_q     <= code;
      chan.profile <= profile;
      if (code == '0) begin
        // RULE3 code zero floats
        chan.drive <= 1'b0;
        chan.level <= '0;
        gliding_q  <= 1'b0;
        chan.mode  <= HVDC_NORMAL;
      end else if (glideEn) begin
        // RULE8 glide overrides turbo
        chan.mode  <= HVDC_GLIDE;
        chan.drive <= 1'b1;
        start_q    <= chan.level;
        step_q     <= 8'h00;
        gliding_q  <= 1'b1;
      end else begin
        // RULE5 normal direct step
        // RULE6 turbo shaped step
        chan.mode  <= fastSettle ? HVDC_TURBO : HVDC_NORMAL;
        chan.drive <= 1'b1;
        chan.level <= code;
        gliding_q  <= 1'b0;
      end
    end else if (gliding_q && stepTick) begin
      // RULE9 ramp over 256 steps
      // RULE10 equal timed increments
      step_q     <= step_q + 8'h01;
      chan.level <= hvdc_ramp_point(start_q, target_q, {1'b0, step_q} + 9'h001);
      if (step_q == 8'(RAMP_STEPS - 1)) begin
        gliding_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // settle timer: the analog stage needs this long after a direct step
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_q <= 16'h0000;
    end else if (load && code != '0 && !glideEn) begin
      settle_q <= fastSettle ? 16'(TURBO_CYC) : 16'(NORMAL_CYC);
    end else if (load) begin
      settle_q <= 16'h0000;
    end else if (settle_q != 16'h0000) begin
      settle_q <= settle_q - 16'h0001;
    end
  end

  // settled once no ramp and no step is still in flight
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settled <= 1'b1;
    end else begin
      settled <= !load && !gliding_q && (settle_q == 16'h0000);
    end
  end

endmodule : hvdc_channel
`default_nettype wire

// ### rtl/hvdc_ctrl.sv
//
// Behaviour
// RULE1 - six independent 7-bit output codes, one per output, written over the bus
// RULE2 - nonzero codes map linearly, 188 mV per code step up to about 24 V
// RULE3 - a zero code puts its output into high impedance
// RULE4 - mode chosen by code-register top bit and the ramp enable bits
// RULE5 - normal mode steps directly, settled within 10 us
// RULE6 - turbo mode shapes the step, load settled within 55 us
// RULE7 - turbo uses a 2-bit load profile per output, registers 9 to 11
// RULE8 - ramp enable set forces glide mode, fast settle bit ignored
// RULE9 - glide lasts 256 times the programmed step period
// RULE10 - glide built from 256 equal timed increments toward the new code
`timescale 1ns/10ps
`default_nettype none
module hvdc_ctrl
  import hvdc_pkg::*;
#(
  parameter int TURBO_CYC = SETTLE_TURBO_CYC,
  parameter int UNIT_CYC  = STEP_UNIT_CYC
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output hvdc_chan_t [NUM_OUT-1:0] hvOutputsAToF,
  output logic [NUM_OUT-1:0]       outSettled
);

  // the channel settle counter is 16 bits and the step timer allows at most 255 cycles per unit
  if (TURBO_CYC < 1 || TURBO_CYC > 65535 || UNIT_CYC < 1 || UNIT_CYC > 255) begin : g_chk
    $error("hvdc_ctrl: timing parameters out of range");
  end

  // two timer groups of three outputs and three profile registers are wired for six
  if (NUM_OUT != 6) begin : g_chk_out
    $error("hvdc_ctrl: six outputs expected");
  end

  // ---------------------------------------------------------------------------
  // register map, byte address is four times the index
  // ---------------------------------------------------------------------------
  // index 1      ramp control for A to C
  //              bits 2:0 glide enable of A, B and C
  //              bits 7:3 step code, step period of (code + 1) units
  // index 2 to 4 output codes of A to C
  //              bits 6:0 code, zero floats the output
  //              bit 7 fast settle, ignored while glide is enabled
  // index 5      ramp control for D to F, laid out as index 1
  // index 6 to 8 output codes of D to F, laid out as index 2
  // index 9      load profiles, bits 1:0 for A and bits 3:2 for B
  // index 10     load profiles of C and D, same layout
  // index 11     load profiles of E and F, same layout
  // index 12     status, one settled bit per output, read only
  // index 16-21  readback of A to F, read only
  //              bits 6:0 live level
  //              bit 7 high impedance
  //              bits 23:8 nominal level in millivolts
  //              bit 24 settled
  // indices 0, 13 to 15 and 22 upward answer with pslverr and read zero;
  // writes to status and readback are dropped without an error
  //
  // a changed mode, glide enable or profile only acts on the next code
  // write, so software sets the controls first and the code last
  //
  // timing: zero wait states; a write and its load pulse land together at the
  // access edge, and the outputs change two edges after the write edge;
  // a code write to a glide output restarts its group timer
  //
  // the first glide step comes one full step period after the load, and
  // the ramp ends after 256 such steps exactly on the new code
  //
  // the millivolt field is nominal, 188 mV per code step; it carries none
  // of the analog stage's gain or offset error

  // ---------------------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------------------
  logic [7:0]         codeReg_q [NUM_OUT];
  logic [7:0]         rampAbc_q;
  logic [7:0]         rampDef_q;
  logic [7:0]         profReg_q [3];
  logic [NUM_OUT-1:0] loadPulse_q;

  logic [5:0]  idx;
  logic        wrEn;
  logic        rdEn;
  logic        mapped;
  logic [31:0] rdData;
  hvdc_chan_t [NUM_OUT-1:0] chanOut;
  logic [NUM_OUT-1:0]       chanSettled;
  logic [1:0]  tick;

  assign idx = paddr[7:2];

  // index of the code register that feeds output n
  function automatic logic [5:0] code_idx(input int n);
    return (n < 3) ? 6'(IDX_CODE_A + 6'(n)) : 6'(IDX_CODE_D + 6'(n - 3));
  endfunction : code_idx

  // ---------------------------------------------------------------------------
  // apb slave: one wait-free access, answer from flip-flops
  // ---------------------------------------------------------------------------
  // pready rises for the access cycle that follows each setup cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  assign wrEn = psel && penable && pready && pwrite;
  assign rdEn = psel && !penable && !pwrite;

  // address decode, used for both read data and the error answer
  always_comb begin
    mapped = 1'b0;
    if (idx == IDX_RAMP_ABC || idx == IDX_RAMP_DEF || idx == IDX_STATUS) begin
      mapped = 1'b1;
    end
    if (idx >= IDX_CODE_A && idx <= IDX_PROF_EF) begin
      mapped = 1'b1;
    end
    if (idx >= IDX_LEVEL_A && idx <= IDX_LEVEL_F) begin
      mapped = 1'b1;
    end
  end

  // error flag is captured in setup so it stands through the access cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !mapped;
    end
  end

  // ---------------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------------
  // RULE1 six code registers
  // RULE4 top bit selects fast settle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < NUM_OUT; n++) begin
        codeReg_q[n] <= RST_CODE;
      end
      loadPulse_q <= '0;
    end else begin
      loadPulse_q <= '0;
      for (int n = 0; n < NUM_OUT; n++) begin
        if (wrEn && idx == code_idx(n)) begin
          codeReg_q[n]   <= pwdata[7:0];
          loadPulse_q[n] <= 1'b1;
        end
      end
    end
  end

  // RULE4 ramp enables and step period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rampAbc_q <= RST_RAMP;
      rampDef_q <= RST_RAMP;
    end else if (wrEn && idx == IDX_RAMP_ABC) begin
      rampAbc_q <= pwdata[7:0];
    end else if (wrEn && idx == IDX_RAMP_DEF) begin
      rampDef_q <= pwdata[7:0];
    end
  end

  // RULE7 load profile registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int r = 0; r < 3; r++) begin
        profReg_q[r] <= RST_PROF;
      end
    end else begin
      for (int r = 0; r < 3; r++) begin
        if (wrEn && idx == 6'(IDX_PROF_AB + 6'(r))) begin
          profReg_q[r] <= pwdata[7:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // level readback shows the live ramp value, not the programmed code
  always_comb begin
    rdData = 32'h0000_0000;
    for (int n = 0; n < NUM_OUT; n++) begin
      if (idx == code_idx(n)) begin
        rdData = {24'h000000, codeReg_q[n]};
      end
      if (idx == 6'(IDX_LEVEL_A + 6'(n))) begin
        // RULE2 level in millivolts
        rdData[CODE_W-1:0]              = chanOut[n].level;
        rdData[RB_HIZ_BIT]              = !chanOut[n].drive;
        rdData[RB_MV_LSB +: 16]         = hvdc_level_mv(chanOut[n].level);
        rdData[RB_SETTLED_BIT]          = chanSettled[n];
      end
    end
    for (int r = 0; r < 3; r++) begin
      if (idx == 6'(IDX_PROF_AB + 6'(r))) begin
        rdData = {24'h000000, profReg_q[r]};
      end
    end
    if (idx == IDX_RAMP_ABC) begin
      rdData = {24'h000000, rampAbc_q};
    end
    if (idx == IDX_RAMP_DEF) begin
      rdData = {24'h000000, rampDef_q};
    end
    if (idx == IDX_STATUS) begin
      rdData = {26'h0000000, chanSettled};
    end
  end

  // read data latched in setup, held through the access cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      prdata <= mapped ? rdData : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // step timers, one per group of three outputs
  // ---------------------------------------------------------------------------
  // RULE9 step period per group
  hvdc_step_tick #(
    .UNIT_CYC (UNIT_CYC)
  ) u_tick_abc (
    .clk      (clk),
    .nrst     (nrst),
    .restart  (|loadPulse_q[2:0]),
    .stepCode (rampAbc_q[STEP_CODE_LSB +: STEP_CODE_W]),
    .tick     (tick[0])
  );

  hvdc_step_tick #(
    .UNIT_CYC (UNIT_CYC)
  ) u_tick_def (
    .clk      (clk),
    .nrst     (nrst),
    .restart  (|loadPulse_q[5:3]),
    .stepCode (rampDef_q[STEP_CODE_LSB +: STEP_CODE_W]),
    .tick     (tick[1])
  );

  // ---------------------------------------------------------------------------
  // output channels
  // ---------------------------------------------------------------------------
  // a restart of the shared timer also bends an ongoing ramp of a sibling
  // output; accepted to keep one timer per group
  for (genvar n = 0; n < NUM_OUT; n++) begin : g_chan
    localparam int GRP = n / 3;
    localparam int SUB = n % 3;
    logic [7:0] rampReg;
    logic [7:0] profReg;
    assign rampReg = (GRP == 0) ? rampAbc_q : rampDef_q;
    assign profReg = profReg_q[n / 2];

    hvdc_channel #(
      .NORMAL_CYC (SETTLE_NORMAL_CYC),
      .TURBO_CYC  (TURBO_CYC)
    ) u_chan (
      .clk        (clk),
      .nrst       (nrst),
      .load       (loadPulse_q[n]),
      .code       (codeReg_q[n][CODE_W-1:0]),
      .fastSettle (codeReg_q[n][FAST_SETTLE_BIT]),
      .glideEn    (rampReg[SUB]),
      .profile    (profReg[2*(n%2) +: 2]),
      .stepTick   (tick[GRP]),
      .chan       (chanOut[n]),
      .settled    (chanSettled[n])
    );
  end

  // outputs are registered once more so the top drives from its own flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hvOutputsAToF <= '0;
      outSettled    <= '1;
    end else begin
      hvOutputsAToF <= chanOut;
      outSettled    <= chanSettled;
    end
  end

endmodule : hvdc_ctrl
`default_nettype wire

// ### dv/hvdc_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module hvdc_ctrl_sva
  import hvdc_pkg::*;
#(
  parameter int TURBO_CYC = SETTLE_TURBO_CYC,
  parameter int UNIT_CYC  = STEP_UNIT_CYC
) (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire hvdc_chan_t [NUM_OUT-1:0]   hvOutputsAToF,
  input wire logic [NUM_OUT-1:0]         outSettled
);
  // ----
  // shadow of output A controls
  // ----
  logic       wrEdge;
  logic       glideA_q;
  logic [1:0] profA_q;
  assign wrEdge = psel && penable && pready && pwrite;
  // track glide enable and profile of A as software sets them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      glideA_q <= 1'b0;
      profA_q  <= 2'h0;
    end else if (wrEdge) begin
      if (paddr[7:2] == IDX_RAMP_ABC) glideA_q <= pwdata[0];
      if (paddr[7:2] == IDX_PROF_AB) profA_q <= pwdata[1:0];
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence wrCodeA;
    wrEdge && paddr[7:2] == IDX_CODE_A;
  endsequence
  sequence wrLiveA;
    wrCodeA ##0 pwdata[6:0] != 7'h00;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_only: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_err_unmap: assert property (pready && paddr[7:2] == 6'h3F |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_hiz_zero: assert property (wrCodeA ##0 pwdata[6:0] == 7'h00 |-> ##3 !hvOutputsAToF[0].drive)
    else $error("zero code still drives");
  a_normal_step: assert property (wrLiveA ##0 (!pwdata[7] && !glideA_q) |-> ##3
    (hvOutputsAToF[0].drive && hvOutputsAToF[0].mode == HVDC_NORMAL && hvOutputsAToF[0].level == $past(pwdata[6:0], 3)))
    else $error("normal step wrong");
  a_turbo_prof: assert property (wrLiveA ##0 (pwdata[7] && !glideA_q) |-> ##3
    (hvOutputsAToF[0].mode == HVDC_TURBO && hvOutputsAToF[0].profile == $past(profA_q, 3)))
    else $error("turbo mode or profile wrong");
  a_glide_force: assert property (wrLiveA ##0 glideA_q |-> ##3 hvOutputsAToF[0].mode == HVDC_GLIDE)
    else $error("glide not selected");
  a_settle_drop: assert property (wrLiveA |-> ##3 !outSettled[0])
    else $error("settled flag kept high");
endmodule : hvdc_ctrl_sva
bind hvdc_ctrl hvdc_ctrl_sva #(.TURBO_CYC(TURBO_CYC), .UNIT_CYC(UNIT_CYC)) hvdc_ctrl_sva_i (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hvOutputsAToF(hvOutputsAToF), .outSettled(outSettled));
`default_nettype wire

// ### dv/hvdc_apb_master.sv
`timescale 1ns/10ps
`default_nettype none
module hvdc_apb_master (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ----
  // bus master
  // ----
  // idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // one transfer; psel stays up when another setup follows at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic last,
                      output logic [31:0] rd, output logic err);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    penable <= 1'b0;
    // an idle edge after the last transfer keeps psel to one assignment per time step
    if (last) begin
      psel <= 1'b0;
      @(posedge clk);
    end
  endtask : xfer
endmodule : hvdc_apb_master
`default_nettype wire

// ### dv/tb_hv_dac_output_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_hv_dac_output_mode_control;
  import hvdc_pkg::*;
  localparam int TC = 20;
  localparam int UC = 2;
  localparam int P  = 2 * UC;  // glide step period for step code 1
  logic                     clk = 1'b0;
  logic                     nrst = 1'b0;
  logic                     psel, penable, pwrite, pready, pslverr;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rdv;
  logic                     rerr;
  hvdc_chan_t [NUM_OUT-1:0] outs;
  logic [NUM_OUT-1:0]       sett;
  int                       errors = 0;
  int                       checked = 0;
  int                       seed = 38842;
  int                       cyc = 0;
  int                       mreg [64] = '{default: 0};
  int                       c, hit, lv, prev;

  hvdc_ctrl #(.TURBO_CYC(TC), .UNIT_CYC(UC)) hvdc_ctrl_i (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hvOutputsAToF(outs), .outSettled(sett));
  hvdc_apb_master hvdc_apb_master_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----
  // clock, timeout, helpers
  // ----
  always #4 clk = ~clk;
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic bit mapped(input int i);
    return (i >= 1 && i <= 12) || (i >= 16 && i <= 21);
  endfunction : mapped
  function automatic int codeOf(input int n);
    return mreg[n < 3 ? n + 2 : n + 3] & 127;
  endfunction : codeOf
  // readback word: level, hi-Z flag, millivolts, settled
  function automatic int rbExp(input int n, input int s);
    return codeOf(n) | ((codeOf(n) == 0) << 7) | ((codeOf(n) * 188) << 8) | (s << 24);
  endfunction : rbExp
  task automatic wr(input int i, input int d, input logic last);
    hvdc_apb_master_i.xfer(1'b1, 8'(i * 4), 32'(d), last, rdv, rerr);
    if (i >= 1 && i <= 11) mreg[i] = d & 255;
    chk("write error", 32'(!mapped(i)), 32'(rerr));
  endtask : wr
  task automatic rd(input int i, input int e);
    hvdc_apb_master_i.xfer(1'b0, 8'(i * 4), 32'h0, 1'b1, rdv, rerr);
    chk("read data", 32'(e), rdv);
    chk("read error", 32'(!mapped(i)), 32'(rerr));
  endtask : rd
  task automatic chk_all(input int md, input int s);
    for (int n = 0; n < NUM_OUT; n++) begin
      chk("level", 32'(codeOf(n)), 32'(outs[n].level));
      chk("drive", 32'(codeOf(n) != 0), 32'(outs[n].drive));
      if (codeOf(n) != 0) chk("mode", 32'(md), 32'(outs[n].mode));
      rd(16 + n, rbExp(n, s));
    end
  endtask : chk_all

  // ----
  // main sequence
  // ----
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("settled after reset", 32'h3F, 32'(sett));
    chk_all(0, 1);
    for (int i = 0; i < 14; i++) rd(i, i == 12 ? 32'h3F : mreg[i]);
    wr(12, 32'h0, 1'b1);
    rd(12, 32'h3F);
    rd(63, 0);
    // normal mode, written back to back: A full scale, C zero
    for (int n = 0; n < NUM_OUT; n++) begin
      c = (n == 0) ? 127 : (n == 2) ? 0 : 1 + $unsigned($random(seed)) % 127;
      wr(n < 3 ? n + 2 : n + 3, c, n == NUM_OUT - 1);
    end
    repeat (100) @(posedge clk);
    for (int n = 0; n < NUM_OUT; n++) if (codeOf(n) != 0) chk("busy", 0, 32'(sett[n]));
    repeat (1160) @(posedge clk);
    chk_all(HVDC_NORMAL, 1);
    // turbo, profiles A..F = 0,1,2,3,0,1
    wr(9, 32'h04, 1'b0);
    wr(10, 32'h0E, 1'b0);
    wr(11, 32'h04, 1'b1);
    for (int n = 0; n < NUM_OUT; n++) begin
      c = 128 + 1 + $unsigned($random(seed)) % 127;
      wr(n < 3 ? n + 2 : n + 3, c, n == NUM_OUT - 1);
    end
    repeat (4) @(posedge clk);
    chk("turbo busy", 0, 32'(sett));
    repeat (TC + 6) @(posedge clk);
    chk_all(HVDC_TURBO, 1);
    for (int n = 0; n < NUM_OUT; n++) chk("profile", 32'(n % 4), 32'(outs[n].profile));
    rd(12, 32'h3F);
    // glide A from hi-Z to full scale, fast settle bit set but ignored
    wr(2, 0, 1'b1);
    wr(1, 32'h0F, 1'b1);
    wr(2, 32'hFF, 1'b1);
    prev = 0;
    hit  = 0;
    for (int k = 1; k <= 256 * P + 20; k++) begin
      @(posedge clk);
      lv = outs[0].level;
      chk("glide slew", 1, 32'(lv >= prev && lv <= prev + 1));
      if (k > 4) chk("glide mode", 32'(HVDC_GLIDE), 32'(outs[0].mode));
      if (lv == 127 && hit == 0) hit = k;
      prev = lv;
    end
    chk("glide time", 1, 32'(hit >= 255 * P && hit <= 256 * P + 10));
    chk("glide end", 127, 32'(outs[0].level));
    for (int i = 1; i < 12; i++) rd(i, mreg[i]);
    give_verdict();
  end
endmodule : tb_hv_dac_output_mode_control
`default_nettype wire
